// *** hw/uemcr_cfg.svh ***
// register offsets, field positions, reset values and sizes of the endpoint mode/count bank
`ifndef UEMCR_CFG_SVH
`define UEMCR_CFG_SVH

`define UEMCR_CNT1_OFS 8'h11
`define UEMCR_MODE_A0_OFS 8'h12
`define UEMCR_CNT2_OFS 8'h13
`define UEMCR_MODE_A1_OFS 8'h14
`define UEMCR_CNT3_OFS 8'h15
`define UEMCR_MODE_A2_OFS 8'h16
`define UEMCR_CNT4_OFS 8'h41
`define UEMCR_MODE_B0_OFS 8'h42
`define UEMCR_CNT5_OFS 8'h43
`define UEMCR_MODE_B1_OFS 8'h44

`define UEMCR_REG_RESET 8'h00
`define UEMCR_MODE_DISABLE 4'h0
`define UEMCR_MODE_NAK_INOUT 4'h1

`define UEMCR_ACK_BIT 4
`define UEMCR_OUT_BIT 5
`define UEMCR_IN_BIT 6
`define UEMCR_SETUP_BIT 7
`define UEMCR_STALL_BIT 7
`define UEMCR_VALID_BIT 6
`define UEMCR_TOGGLE_BIT 7
`define UEMCR_CFG_ADDR_BIT 0

`define UEMCR_NUM_EP 5
`define UEMCR_EP_A0 3'd0
`define UEMCR_EP_B0 3'd3
`define UEMCR_NUM_LOCK 4

`endif

// *** hw/uemcr_lock.sv ***
// write-lock flags of the endpoint-zero mode and counter registers
`timescale 1ns/1ps
module uemcr_lock #(
  parameter int N = 4
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [N-1:0] en_i,
  input wire logic [N-1:0] upd_i,
  input wire logic [N-1:0] rd_i,
  output logic [N-1:0] locked_o
);
  // an engine update in the same cycle as a read keeps the lock, so no update is missed
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      locked_o <= '0;
    end else begin
      locked_o <= en_i & (upd_i | (locked_o & ~rd_i));
    end
  end
endmodule // uemcr_lock

// *** hw/uemcr_pkg.sv ***
// types shared by the endpoint mode/count bank
package uemcr_pkg;
  typedef enum logic [1:0] {
    UEMCR_PID_SETUP,
    UEMCR_PID_IN,
    UEMCR_PID_OUT
  } uemcr_pid_e;

  typedef enum logic [2:0] {
    UEMCR_RESP_IGNORE,
    UEMCR_RESP_ACK,
    UEMCR_RESP_NAK,
    UEMCR_RESP_STALL,
    UEMCR_RESP_CHECK,
    UEMCR_RESP_TX_COUNT,
    UEMCR_RESP_TX_ZERO,
    UEMCR_RESP_ALWAYS
  } uemcr_resp_e;

  typedef logic [7:0] uemcr_reg_t;
endpackage

// *** hw/uemcr_regs.sv ***
// endpoint mode and byte-counter register bank between the I/O port and the serial engine
`timescale 1ns/1ps
`include "uemcr_cfg.svh"
module uemcr_regs
  import uemcr_pkg::*;
#(
  parameter int NUM_EP = `UEMCR_NUM_EP
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  input wire logic [1:0] ep_config_i,
  input wire logic sie_token_i,
  input wire logic [2:0] sie_token_ep_i,
  input wire uemcr_pid_e sie_pid_i,
  input wire logic sie_data_start_i,
  input wire logic sie_ack_start_i,
  input wire logic sie_done_i,
  input wire logic [2:0] sie_done_ep_i,
  input wire logic sie_acked_i,
  input wire logic sie_rx_data_i,
  input wire logic sie_crc_ok_i,
  input wire logic sie_toggle_i,
  input wire logic [5:0] sie_rx_count_i,
  output logic resp_valid_o,
  output uemcr_resp_e resp_o,
  output logic [5:0] tx_count_o,
  output logic tx_toggle_o,
  output logic [NUM_EP-1:0] ep_int_o,
  output logic [1:0] fifo_wr_block_o
);

  function automatic logic [7:0] mode_addr(input int i);
    case (i)
      0: mode_addr = `UEMCR_MODE_A0_OFS;
      1: mode_addr = `UEMCR_MODE_A1_OFS;
      2: mode_addr = `UEMCR_MODE_A2_OFS;
      3: mode_addr = `UEMCR_MODE_B0_OFS;
      default: mode_addr = `UEMCR_MODE_B1_OFS;
    endcase
  endfunction

  function automatic logic [7:0] cnt_addr(input int i);
    case (i)
      0: cnt_addr = `UEMCR_CNT1_OFS;
      1: cnt_addr = `UEMCR_CNT2_OFS;
      2: cnt_addr = `UEMCR_CNT3_OFS;
      3: cnt_addr = `UEMCR_CNT4_OFS;
      default: cnt_addr = `UEMCR_CNT5_OFS;
    endcase
  endfunction

  // endpoint 0 of address A is always control; endpoint 3 only while two addresses are set
  function automatic logic is_ctl(input int i, input logic single_addr);
    is_ctl = (i == 0) || ((i == 3) && !single_addr);
  endfunction

  uemcr_reg_t mode [NUM_EP];
  uemcr_reg_t cnt [NUM_EP];
  uemcr_reg_t next_mode [NUM_EP];
  uemcr_reg_t next_cnt [NUM_EP];
  logic [NUM_EP-1:0] ctl;
  logic [NUM_EP-1:0] mode_wr;
  logic [NUM_EP-1:0] cnt_wr;
  logic [NUM_EP-1:0] mode_rd;
  logic [NUM_EP-1:0] cnt_rd;
  logic [NUM_EP-1:0] tok_hit;
  logic [NUM_EP-1:0] done_hit;
  logic [NUM_EP-1:0] mode_upd;
  logic [NUM_EP-1:0] cnt_upd;
  logic [NUM_EP-1:0] mode_lock;
  logic [NUM_EP-1:0] cnt_lock;
  logic [`UEMCR_NUM_LOCK-1:0] lock_en;
  logic [`UEMCR_NUM_LOCK-1:0] lock_upd;
  logic [`UEMCR_NUM_LOCK-1:0] lock_rd;
  logic [`UEMCR_NUM_LOCK-1:0] lock_q;
  logic single_addr;
  logic setup_force;
  logic [2:0] force_ep;
  logic last_setup;
  logic [2:0] last_ep;
  logic [7:0] next_rdata;

  assign single_addr = ep_config_i[`UEMCR_CFG_ADDR_BIT];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_EP; gi++) begin : g_ep
      assign ctl[gi] = is_ctl(gi, single_addr);
      assign mode_wr[gi] = io_wr_i && (io_addr_i == mode_addr(gi));
      assign cnt_wr[gi] = io_wr_i && (io_addr_i == cnt_addr(gi));
      assign mode_rd[gi] = io_rd_i && (io_addr_i == mode_addr(gi));
      assign cnt_rd[gi] = io_rd_i && (io_addr_i == cnt_addr(gi));
      // a disabled endpoint takes no token updates, but a done for it still sets its ack flag, counter and locks
      assign tok_hit[gi] = sie_token_i && (sie_token_ep_i == 3'(gi))
                           && (mode[gi][3:0] != `UEMCR_MODE_DISABLE);
      assign done_hit[gi] = sie_done_i && (sie_done_ep_i == 3'(gi));
      // the engine touches bits 6..0 at the token and again when the transaction is acked
      assign mode_upd[gi] = ctl[gi] && (tok_hit[gi] || (done_hit[gi] && sie_acked_i));
      assign cnt_upd[gi] = ctl[gi] && done_hit[gi] && sie_rx_data_i;

      always_comb begin
        next_mode[gi] = mode[gi];
        if (mode_wr[gi]) begin
          if (ctl[gi]) begin
            if (!mode_lock[gi]) begin
              next_mode[gi][6:0] = io_wdata_i[6:0];
            end
            next_mode[gi][`UEMCR_SETUP_BIT] = 1'b0;
          end else begin
            next_mode[gi] = io_wdata_i;
          end
        end
        if (tok_hit[gi] && ctl[gi]) begin
          next_mode[gi][`UEMCR_OUT_BIT] = (sie_pid_i == UEMCR_PID_OUT);
          next_mode[gi][`UEMCR_IN_BIT] = (sie_pid_i == UEMCR_PID_IN);
          if (sie_pid_i == UEMCR_PID_SETUP) begin
            next_mode[gi][`UEMCR_SETUP_BIT] = 1'b1;
            if (mode[gi][3:0] != `UEMCR_MODE_DISABLE) begin
              next_mode[gi][3:0] = `UEMCR_MODE_NAK_INOUT;
            end
          end
        end
        if (done_hit[gi] && sie_acked_i) begin
          next_mode[gi][`UEMCR_ACK_BIT] = 1'b1;
          if (next_mode[gi][3] && next_mode[gi][0]) begin
            next_mode[gi][0] = 1'b0;
          end
        end
        // the forced level wins over any CPU clear during the SETUP data phase
        if (ctl[gi] && setup_force && (force_ep == 3'(gi))) begin
          next_mode[gi][`UEMCR_SETUP_BIT] = 1'b1;
        end
      end

      always_comb begin
        next_cnt[gi] = cnt[gi];
        if (cnt_wr[gi] && !cnt_lock[gi]) begin
          next_cnt[gi] = io_wdata_i;
        end
        if (done_hit[gi] && sie_rx_data_i) begin
          next_cnt[gi][5:0] = sie_rx_count_i;
          next_cnt[gi][`UEMCR_VALID_BIT] = sie_crc_ok_i;
          next_cnt[gi][`UEMCR_TOGGLE_BIT] = sie_toggle_i;
        end
      end

      always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          mode[gi] <= `UEMCR_REG_RESET;
          cnt[gi] <= `UEMCR_REG_RESET;
        end else begin
          mode[gi] <= next_mode[gi];
          cnt[gi] <= next_cnt[gi];
        end
      end

      // a failed CRC still interrupts so firmware can see data-valid low
      always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          ep_int_o[gi] <= 1'b0;
        end else begin
          ep_int_o[gi] <= done_hit[gi] && (sie_acked_i || sie_rx_data_i);
        end
      end
    end
  endgenerate

  // lock slots: 0 mode A0, 1 mode B0, 2 counter A0, 3 counter B0
  assign lock_en = {ctl[3], 1'b1, ctl[3], 1'b1};
  assign lock_upd = {cnt_upd[3], cnt_upd[0], mode_upd[3], mode_upd[0]};
  assign lock_rd = {cnt_rd[3], cnt_rd[0], mode_rd[3], mode_rd[0]};

  uemcr_lock #(
    .N(`UEMCR_NUM_LOCK)
  ) u_lock (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .en_i(lock_en),
    .upd_i(lock_upd),
    .rd_i(lock_rd),
    .locked_o(lock_q)
  );

  always_comb begin
    mode_lock = '0;
    cnt_lock = '0;
    mode_lock[`UEMCR_EP_A0] = lock_q[0];
    mode_lock[`UEMCR_EP_B0] = lock_q[1];
    cnt_lock[`UEMCR_EP_A0] = lock_q[2];
    cnt_lock[`UEMCR_EP_B0] = lock_q[3];
  end

  // remembers which endpoint the current token was for, so the data phase can force SETUP
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      last_setup <= 1'b0;
      last_ep <= 3'h0;
    end else if (sie_token_i) begin
      last_setup <= (sie_pid_i == UEMCR_PID_SETUP) && |(tok_hit & ctl);
      last_ep <= sie_token_ep_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      setup_force <= 1'b0;
      force_ep <= 3'h0;
    end else if (sie_ack_start_i || sie_done_i) begin
      setup_force <= 1'b0;
    end else if (sie_data_start_i && last_setup) begin
      setup_force <= 1'b1;
      force_ep <= last_ep;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fifo_wr_block_o <= 2'b00;
    end else begin
      fifo_wr_block_o[0] <= next_mode[`UEMCR_EP_A0][`UEMCR_SETUP_BIT];
      fifo_wr_block_o[1] <= ctl[3] && next_mode[`UEMCR_EP_B0][`UEMCR_SETUP_BIT];
    end
  end

  // unmapped addresses read as zero
  always_comb begin
    next_rdata = 8'h00;
    for (int i = 0; i < NUM_EP; i++) begin
      if (io_addr_i == mode_addr(i)) begin
        next_rdata = mode[i];
      end
      if (io_addr_i == cnt_addr(i)) begin
        next_rdata = cnt[i];
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      io_rdata_o <= 8'h00;
    end else if (io_rd_i) begin
      io_rdata_o <= next_rdata;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_count_o <= 6'h00;
      tx_toggle_o <= 1'b0;
    end else if (sie_token_i) begin
      tx_count_o <= cnt[sie_token_ep_i][5:0];
      tx_toggle_o <= cnt[sie_token_ep_i][`UEMCR_TOGGLE_BIT];
    end
  end

  uemcr_resp u_resp (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .token_i(sie_token_i),
    .pid_i(sie_pid_i),
    .mode_i(mode[sie_token_ep_i][3:0]),
    .stall_i(!ctl[sie_token_ep_i] && mode[sie_token_ep_i][`UEMCR_STALL_BIT]),
    .ctl_i(ctl[sie_token_ep_i]),
    .valid_o(resp_valid_o),
    .resp_o(resp_o)
  );

endmodule // uemcr_regs

// *** hw/uemcr_resp.sv ***
// handshake choice for a token, from the endpoint mode and stall bit
`timescale 1ns/1ps
module uemcr_resp
  import uemcr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic token_i,
  input wire uemcr_pid_e pid_i,
  input wire logic [3:0] mode_i,
  input wire logic stall_i,
  input wire logic ctl_i,
  output logic valid_o,
  output uemcr_resp_e resp_o
);
  uemcr_resp_e next_resp;
  uemcr_resp_e r_setup;
  uemcr_resp_e r_in;
  uemcr_resp_e r_out;

  always_comb begin
    r_setup = UEMCR_RESP_IGNORE;
    r_in = UEMCR_RESP_IGNORE;
    r_out = UEMCR_RESP_IGNORE;
    case (mode_i)
      4'h0: r_setup = UEMCR_RESP_IGNORE;
      4'h1: begin
        r_setup = UEMCR_RESP_ACK;
        r_in = UEMCR_RESP_NAK;
        r_out = UEMCR_RESP_NAK;
      end
      4'h2: begin
        r_setup = UEMCR_RESP_ACK;
        r_in = UEMCR_RESP_STALL;
        r_out = UEMCR_RESP_CHECK;
      end
      4'h3: begin
        r_setup = UEMCR_RESP_ACK;
        r_in = UEMCR_RESP_STALL;
        r_out = UEMCR_RESP_STALL;
      end
      4'h4: r_setup = UEMCR_RESP_ACK;
      4'h5: r_out = UEMCR_RESP_ALWAYS;
      4'h6: begin
        r_setup = UEMCR_RESP_ACK;
        r_in = UEMCR_RESP_TX_ZERO;
        r_out = UEMCR_RESP_STALL;
      end
      4'h7: r_in = UEMCR_RESP_TX_COUNT;
      4'h8: r_out = UEMCR_RESP_NAK;
      4'h9: begin
        r_out = UEMCR_RESP_ACK;
        if (stall_i) begin
          r_in = UEMCR_RESP_STALL;
        end
      end
      4'ha: begin
        r_setup = UEMCR_RESP_ACK;
        r_in = UEMCR_RESP_TX_ZERO;
        r_out = UEMCR_RESP_NAK;
      end
      4'hb: begin
        r_setup = UEMCR_RESP_ACK;
        r_in = UEMCR_RESP_TX_ZERO;
        r_out = UEMCR_RESP_ACK;
      end
      4'hc: r_in = UEMCR_RESP_NAK;
      4'hd: begin
        r_in = UEMCR_RESP_TX_COUNT;
        if (stall_i) begin
          r_out = UEMCR_RESP_STALL;
        end
      end
      4'he: begin
        r_setup = UEMCR_RESP_ACK;
        r_in = UEMCR_RESP_NAK;
        r_out = UEMCR_RESP_CHECK;
      end
      default: begin
        r_setup = UEMCR_RESP_ACK;
        r_in = UEMCR_RESP_TX_COUNT;
        r_out = UEMCR_RESP_CHECK;
      end
    endcase
    case (pid_i)
      UEMCR_PID_SETUP: next_resp = ctl_i ? r_setup : UEMCR_RESP_IGNORE;
      UEMCR_PID_IN: next_resp = r_in;
      UEMCR_PID_OUT: next_resp = r_out;
      default: next_resp = UEMCR_RESP_IGNORE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      valid_o <= 1'b0;
      resp_o <= UEMCR_RESP_IGNORE;
    end else begin
      valid_o <= token_i;
      if (token_i) begin
        resp_o <= next_resp;
      end
    end
  end
endmodule // uemcr_resp

// *** tb/uemcr_regs_bench.sv ***
// self-checking bench of the endpoint mode/count bank
`timescale 1ns/1ps
module uemcr_regs_bench;
  import uemcr_pkg::*;
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic io_wr_i = 1'b0;
  logic io_rd_i = 1'b0;
  logic [7:0] io_addr_i = 8'h00;
  logic [7:0] io_wdata_i = 8'h00;
  logic [7:0] io_rdata_o;
  logic [1:0] ep_config_i = 2'h0;
  logic [1:0] fifo_wr_block_o;
  logic sie_token_i, sie_data_start_i, sie_ack_start_i, sie_done_i, sie_acked_i;
  logic sie_rx_data_i, sie_crc_ok_i, sie_toggle_i, resp_valid_o, tx_toggle_o;
  logic [2:0] sie_token_ep_i, sie_done_ep_i;
  logic [5:0] sie_rx_count_i, tx_count_o;
  logic [4:0] ep_int_o;
  uemcr_pid_e sie_pid_i;
  uemcr_resp_e resp_o;
  int n_fail = 0;
  int n_checks = 0;
  localparam logic [7:0] MAP [10] = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h15,
                                      8'h16, 8'h41, 8'h42, 8'h43, 8'h44};

  always #10 ref_clk_i = ~ref_clk_i;

  uemcr_regs #(
    .NUM_EP(5)
  ) u_uemcr_regs (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .io_addr_i(io_addr_i),
    .io_wr_i(io_wr_i),
    .io_rd_i(io_rd_i),
    .io_wdata_i(io_wdata_i),
    .io_rdata_o(io_rdata_o),
    .ep_config_i(ep_config_i),
    .sie_token_i(sie_token_i),
    .sie_token_ep_i(sie_token_ep_i),
    .sie_pid_i(sie_pid_i),
    .sie_data_start_i(sie_data_start_i),
    .sie_ack_start_i(sie_ack_start_i),
    .sie_done_i(sie_done_i),
    .sie_done_ep_i(sie_done_ep_i),
    .sie_acked_i(sie_acked_i),
    .sie_rx_data_i(sie_rx_data_i),
    .sie_crc_ok_i(sie_crc_ok_i),
    .sie_toggle_i(sie_toggle_i),
    .sie_rx_count_i(sie_rx_count_i),
    .resp_valid_o(resp_valid_o),
    .resp_o(resp_o),
    .tx_count_o(tx_count_o),
    .tx_toggle_o(tx_toggle_o),
    .ep_int_o(ep_int_o),
    .fifo_wr_block_o(fifo_wr_block_o)
  );

  uemcr_sie_model u_uemcr_sie_model (
    .ref_clk_i(ref_clk_i),
    .token_o(sie_token_i),
    .tok_ep_o(sie_token_ep_i),
    .pid_o(sie_pid_i),
    .data_o(sie_data_start_i),
    .ackst_o(sie_ack_start_i),
    .done_o(sie_done_i),
    .done_ep_o(sie_done_ep_i),
    .acked_o(sie_acked_i),
    .rx_o(sie_rx_data_i),
    .crc_o(sie_crc_ok_i),
    .tog_o(sie_toggle_i),
    .cnt_o(sie_rx_count_i)
  );

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic resp(input uemcr_resp_e x);
    chk("resp", {5'h0, x}, {5'h0, resp_o});
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    io_addr_i = a;
    io_wdata_i = d;
    io_wr_i = 1'b1;
    @(negedge ref_clk_i);
    io_wr_i = 1'b0;
    io_wdata_i = ~d;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge ref_clk_i);
    io_addr_i = a;
    io_rd_i = 1'b1;
    @(negedge ref_clk_i);
    io_rd_i = 1'b0;
    chk($sformatf("reg %h", a), exp, io_rdata_o);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_fail++;
    report_and_stop();
  end

  initial begin
    repeat (4) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    resetn_i = 1'b1;
    foreach (MAP[i]) rd(MAP[i], 8'h00);
    rd(8'h20, 8'h00);
    wr(8'h12, 8'h01);
    u_uemcr_sie_model.xfer(UEMCR_PID_SETUP, 3'd0, 6'd10, 1'b1, 1'b0, 1'b1);
    resp(UEMCR_RESP_ACK);
    // the counter must not be written before its first read
    wr(8'h11, 8'h05);
    rd(8'h12, 8'h91);
    rd(8'h11, 8'h4a);
    wr(8'h12, 8'h02);
    wr(8'h11, 8'h05);
    rd(8'h12, 8'h02);
    rd(8'h11, 8'h05);
    wr(8'h12, 8'h0b);
    rd(8'h12, 8'h0b);
    u_uemcr_sie_model.xfer(UEMCR_PID_OUT, 3'd0, 6'd2, 1'b0, 1'b1, 1'b1);
    resp(UEMCR_RESP_ACK);
    wr(8'h12, 8'h01);
    rd(8'h12, 8'h3a);
    rd(8'h11, 8'h82);
    wr(8'h12, 8'h0a);
    rd(8'h12, 8'h0a);
    wr(8'h14, 8'h8d);
    u_uemcr_sie_model.xfer(UEMCR_PID_OUT, 3'd1, 6'd2, 1'b1, 1'b0, 1'b0);
    resp(UEMCR_RESP_STALL);
    wr(8'h14, 8'h89);
    u_uemcr_sie_model.xfer(UEMCR_PID_IN, 3'd1, 6'd0, 1'b1, 1'b0, 1'b0);
    resp(UEMCR_RESP_STALL);
    wr(8'h15, 8'ha0);
    wr(8'h16, 8'h0d);
    u_uemcr_sie_model.xfer(UEMCR_PID_IN, 3'd2, 6'd0, 1'b1, 1'b0, 1'b1);
    resp(UEMCR_RESP_TX_COUNT);
    chk("tx", 8'ha0, {tx_toggle_o, 1'b0, tx_count_o});
    wr(8'h16, 8'h0d);
    rd(8'h16, 8'h0d);
    u_uemcr_sie_model.xfer(UEMCR_PID_IN, 3'd2, 6'd0, 1'b1, 1'b0, 1'b1);
    rd(8'h16, 8'h1c);
    for (int p = 0; p < 3; p++) begin
      u_uemcr_sie_model.xfer(uemcr_pid_e'(p), 3'd3, 6'd2, 1'b1, 1'b0, 1'b0);
      resp(UEMCR_RESP_IGNORE);
      chk("block", 8'h00, {6'h0, fifo_wr_block_o});
    end
    ep_config_i = 2'h2;
    wr(8'h42, 8'h01);
    u_uemcr_sie_model.xfer(UEMCR_PID_SETUP, 3'd3, 6'd2, 1'b1, 1'b0, 1'b1);
    chk("block", 8'h02, {6'h0, fifo_wr_block_o});
    rd(8'h42, 8'h91);
    // writing a one to the setup position still clears the flag
    wr(8'h42, 8'h91);
    rd(8'h42, 8'h11);
    ep_config_i = 2'h1;
    wr(8'h42, 8'h8d);
    rd(8'h42, 8'h8d);
    u_uemcr_sie_model.xfer(UEMCR_PID_OUT, 3'd3, 6'd2, 1'b1, 1'b0, 1'b0);
    resp(UEMCR_RESP_STALL);
    report_and_stop();
  end
endmodule // uemcr_regs_bench

// *** tb/uemcr_regs_properties.sv ***
// concurrent checks on the ports of the endpoint mode/count bank
`timescale 1ns/1ps
module uemcr_regs_properties
  import uemcr_pkg::*;
#(
  parameter int NUM_EP = 5
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic io_wr_i,
  input wire logic [7:0] io_rdata_o,
  input wire logic [1:0] ep_config_i,
  input wire logic sie_token_i,
  input wire logic [2:0] sie_token_ep_i,
  input wire uemcr_pid_e sie_pid_i,
  input wire logic sie_data_start_i,
  input wire logic sie_done_i,
  input wire logic [2:0] sie_done_ep_i,
  input wire logic sie_acked_i,
  input wire logic sie_rx_data_i,
  input wire logic resp_valid_o,
  input wire uemcr_resp_e resp_o,
  input wire logic [NUM_EP-1:0] ep_int_o,
  input wire logic [1:0] fifo_wr_block_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);

  sequence setup_tok_s;
    sie_token_i && sie_pid_i == UEMCR_PID_SETUP && sie_token_ep_i == 3'd0;
  endsequence
  sequence setup_accept_s;
    setup_tok_s ##1 resp_o == UEMCR_RESP_ACK;
  endsequence

  resp_pulse_a: assert property (resp_valid_o == $past(sie_token_i))
    else $error("handshake valid not one cycle after token");
  setup_block_a: assert property (setup_accept_s |-> fifo_wr_block_o[0])
    else $error("fifo write block missing after accepted setup");
  // the flag must survive the whole data packet, not only its first cycle
  setup_forced_a: assert property (sie_data_start_i && fifo_wr_block_o[0]
    |=> fifo_wr_block_o[0] [*3])
    else $error("setup flag dropped before ack start");
  setup_rise_a: assert property ($rose(fifo_wr_block_o[0]) |->
    $past(sie_token_i) && $past(sie_pid_i) == UEMCR_PID_SETUP)
    else $error("setup flag rose without setup token");
  setup_fall_a: assert property ($fell(fifo_wr_block_o[0]) |-> $past(io_wr_i))
    else $error("setup flag fell without cpu write");
  int_done_a: assert property (ep_int_o == (($past(sie_done_i) &&
    ($past(sie_acked_i) || $past(sie_rx_data_i))) ? NUM_EP'(1) << $past(sie_done_ep_i) : '0))
    else $error("endpoint interrupt does not follow transaction end");
  reset_read_a: assert property ($rose(resetn_i) |->
    io_rdata_o == 8'h00 && ep_int_o == '0)
    else $error("outputs not clear after reset");
  single_addr_a: assert property (ep_config_i[0] && $past(ep_config_i[0]) |->
    !fifo_wr_block_o[1])
    else $error("second address setup flag active in single-address setting");
endmodule // uemcr_regs_properties

bind uemcr_regs uemcr_regs_properties #(
  .NUM_EP(NUM_EP)
) u_uemcr_regs_properties (
  .ref_clk_i(ref_clk_i),
  .resetn_i(resetn_i),
  .io_wr_i(io_wr_i),
  .io_rdata_o(io_rdata_o),
  .ep_config_i(ep_config_i),
  .sie_token_i(sie_token_i),
  .sie_token_ep_i(sie_token_ep_i),
  .sie_pid_i(sie_pid_i),
  .sie_data_start_i(sie_data_start_i),
  .sie_done_i(sie_done_i),
  .sie_done_ep_i(sie_done_ep_i),
  .sie_acked_i(sie_acked_i),
  .sie_rx_data_i(sie_rx_data_i),
  .resp_valid_o(resp_valid_o),
  .resp_o(resp_o),
  .ep_int_o(ep_int_o),
  .fifo_wr_block_o(fifo_wr_block_o)
);

// *** tb/uemcr_sie_model.sv ***
// serial engine model: one transaction at a time, token, data, ack, done
`timescale 1ns/1ps
module uemcr_sie_model
  import uemcr_pkg::*;
(
  input wire logic ref_clk_i,
  output logic token_o,
  output logic [2:0] tok_ep_o,
  output uemcr_pid_e pid_o,
  output logic data_o,
  output logic ackst_o,
  output logic done_o,
  output logic [2:0] done_ep_o,
  output logic acked_o,
  output logic rx_o,
  output logic crc_o,
  output logic tog_o,
  output logic [5:0] cnt_o
);
  initial begin
    {token_o, tok_ep_o, data_o, ackst_o, done_o, done_ep_o} = '0;
    {acked_o, rx_o, crc_o, tog_o, cnt_o} = '0;
    pid_o = UEMCR_PID_SETUP;
  end

  // qualifiers are inverted outside their cycle so stale values cannot pass
  task automatic xfer(input uemcr_pid_e p, input logic [2:0] e, input logic [5:0] n,
                      input logic crc, input logic tg, input logic ak);
    logic dat;
    dat = (p != UEMCR_PID_IN);
    @(negedge ref_clk_i);
    token_o = 1'b1;
    pid_o = p;
    tok_ep_o = e;
    @(negedge ref_clk_i);
    token_o = 1'b0;
    pid_o = uemcr_pid_e'(~p);
    tok_ep_o = ~e;
    @(negedge ref_clk_i);
    data_o = dat;
    @(negedge ref_clk_i);
    data_o = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    ackst_o = dat && ak;
    @(negedge ref_clk_i);
    ackst_o = 1'b0;
    @(negedge ref_clk_i);
    done_o = 1'b1;
    done_ep_o = e;
    acked_o = ak;
    rx_o = dat && ak;
    crc_o = crc;
    tog_o = tg;
    cnt_o = n;
    @(negedge ref_clk_i);
    done_o = 1'b0;
    done_ep_o = ~e;
    acked_o = ~ak;
    rx_o = ~rx_o;
    crc_o = ~crc;
    tog_o = ~tg;
    cnt_o = ~n;
    @(negedge ref_clk_i);
  endtask
endmodule // uemcr_sie_model
